// [dv/pprc_host_model.sv]
module pprc_host_model (
  input  wire logic clk_sys, // System clock.
  input  wire logic sda_oe,  // Device pulls data low.
  output logic      scl,     // Serial clock.
  output logic      sda      // Data wire level.
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------
  // Bus host that writes and reads registers
  // --------------------------------------------------------------------
  logic drv; // Host drive, one lets the pull-up win.
  // Open drain: the wire is low when either side pulls it.
  assign sda = drv & ~sda_oe;
  // Idle bus: both lines float high.
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  // Phases span 8 clocks, twice what the device needs.
  task automatic ph();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : ph
  // Data only moves mid low phase, so no false start or stop shows.
  // The wire is sampled late in each high phase, where it has settled.
  task automatic bits(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      ph();
      drv = b[i];
      ph();
      scl = 1'b1;
      ph();
      r[i] = sda;
      scl = 1'b0;
    end
  endtask : bits
  // Stop: data rises while the clock is high.
  task automatic stp();
    ph();
    drv = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    drv = 1'b1;
    ph();
  endtask : stp
  // Write one word; ack keeps the level of each ack slot, low is ack.
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [15:0] d, output logic [3:0] ack);
    logic [8:0] r;
    drv = 1'b0;
    ph();
    scl = 1'b0;
    bits({a, 1'b0, 1'b1}, r);
    ack[3] = r[0];
    bits({p, 1'b1}, r);
    ack[2] = r[0];
    bits({d[15:8], 1'b1}, r);
    ack[1] = r[0];
    bits({d[7:0], 1'b1}, r);
    ack[0] = r[0];
    stp();
  endtask : wr
  // Read one word after a pointer write and a repeated start; the host
  // acks the high byte and nacks the low one, which ends the read.
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [15:0] d);
    logic [8:0] r;
    logic [8:0] q;
    drv = 1'b0;
    ph();
    scl = 1'b0;
    bits({a, 1'b0, 1'b1}, r);
    bits({p, 1'b1}, r);
    ph();
    drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    drv = 1'b0;
    ph();
    scl = 1'b0;
    bits({a, 1'b1, 1'b1}, r);
    bits(9'h1FE, r);
    bits(9'h1FF, q);
    d = {r[8:1], q[8:1]};
    stp();
  endtask : rd
endmodule : pprc_host_model

// [dv/test_pprc_top.sv]
module test_pprc_top
  import pprc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------
  // Bench
  // --------------------------------------------------------------------
  localparam logic [6:0] DEV = 7'h3A; // Arbitrary bus address.
  localparam logic [7:0] PTRS [3] = '{PTR_POWER, PTR_PULLDOWN, PTR_CUR_OUT};
  localparam logic [15:0] MSK [3] = '{16'h06FF, 16'h00FF, 16'h000F};
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        adc_busy = 1'b0;
  logic [7:0]  dac_config = 8'h00;
  logic [7:0]  range2x_req = 8'h00;
  logic        scl, sda, sda_oe, soft_reset_pulse, sda_low;
  logic [3:0]  ack; // Ack slot levels of the last write.
  pprc_power_t power;
  pprc_regs_t  m; // Expected register contents.
  int          errors = 0, cmp_count = 0, pulses = 0, seed = 32453, n, k;

  pprc_top #(.DEV_ADDR(DEV)) i_pprc_top (.clk_sys(clk_sys),
    .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_low),
    .sda_oe(sda_oe), .dac_config(dac_config), .range2x_req(range2x_req),
    .adc_busy(adc_busy), .power(power),
    .soft_reset_pulse(soft_reset_pulse));
  pprc_host_model i_pprc_host_model (.clk_sys(clk_sys), .sda_oe(sda_oe),
    .scl(scl), .sda(sda));

  // Free-running 200 MHz clock.
  initial forever #2.5 clk_sys = ~clk_sys;
  // Count keyed reset pulses.
  always @(posedge clk_sys) if (soft_reset_pulse === 1'b1) pulses++;

  function automatic pprc_power_t exp_pw();
    pprc_power_t e;
    logic        off;
    off = m.global_power_down;
    e.pin_pulldown = m.weak_pulldown_select;
    e.cur_out_on = m.current_output_enable & ~m.weak_pulldown_select[3:0]
                   & {4{~off}};
    e.dac_power_on = dac_config & ~m.dac_channel_sleep & {8{~off}};
    e.volt_out_on = e.dac_power_on & ~m.weak_pulldown_select
                    & ~{4'h0, m.current_output_enable};
    e.range2x_on = range2x_req & e.volt_out_on;
    e.ref_power_on = m.ref_enable & ~off;
    e.adc_power_on = adc_busy & ~off;
    return e;
  endfunction : exp_pw

  // Read-back value; reserved and write-only bits read as zero.
  function automatic logic [15:0] exp_rd(logic [7:0] p);
    if (p == PTR_PULLDOWN) return {8'h00, m.weak_pulldown_select};
    if (p == PTR_CUR_OUT) return {12'h000, m.current_output_enable};
    if (p == PTR_POWER) return {5'h00, m.global_power_down, m.ref_enable,
                                1'b0, m.dac_channel_sleep};
    return 16'h0000;
  endfunction : exp_rd

  task automatic check(string s, logic [43:0] e, logic [43:0] g);
    cmp_count++;
    if (e !== g) begin
      errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : check

  task automatic chk_pw();
    repeat (3) @(posedge clk_sys);
    #1;
    check("power", 44'(exp_pw()), 44'(power));
  endtask : chk_pw

  // Read a register back over the bus and compare it with the image.
  task automatic rd(logic [7:0] a);
    logic [15:0] d;
    i_pprc_host_model.rd(DEV, a, d);
    check("read", 44'(exp_rd(a)), 44'(d));
  endtask : rd

  // A write also updates the expected register image.
  task automatic wr(logic [7:0] a, logic [15:0] v);
    i_pprc_host_model.wr(DEV, a, v, ack);
    check("ack", 44'h0, 44'(ack));
    if (a == PTR_POWER) {m.global_power_down, m.ref_enable} = v[10:9];
    if (a == PTR_POWER) m.dac_channel_sleep = v[7:0];
    if (a == PTR_PULLDOWN) m.weak_pulldown_select = v[7:0];
    if (a == PTR_CUR_OUT) m.current_output_enable = v[3:0];
    if (a == PTR_SOFT_RESET && v == SOFT_RESET_KEY) m = REGS_RST;
  endtask : wr

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Main sequence: reset, random writes, corners, keyed reset.
  initial begin
    m = REGS_RST;
    repeat (12) @(posedge clk_sys);
    #1;
    check("reset", 44'(POWER_RST), 44'(power));
    resetn = 1'b1;
    chk_pw();
    $display("test reset done");
    for (n = 0; n < 30; n++) begin
      k = {$random(seed)} % 3;
      {dac_config, range2x_req, adc_busy} = 17'($random(seed));
      wr(PTRS[k], 16'($random(seed)) & MSK[k]);
      chk_pw();
      if (n % 3 == 0) rd(PTRS[k]);
    end
    $display("test random done");
    {dac_config, range2x_req, adc_busy} = '1;
    wr(PTR_PULLDOWN, 16'h0000);
    wr(PTR_CUR_OUT, 16'h000F);
    wr(PTR_POWER, 16'h0200);
    chk_pw();
    rd(PTR_CUR_OUT);
    wr(PTR_POWER, 16'h0400);
    chk_pw();
    rd(PTR_POWER);
    $display("test corners done");
    n = pulses;
    i_pprc_host_model.wr(DEV ^ 7'h01, PTR_PULLDOWN, 16'h00A5, ack);
    check("nack", 44'hF, 44'(ack));
    wr(PTR_SOFT_RESET, SOFT_RESET_KEY ^ 16'h0001);
    chk_pw();
    check("pulses", 44'(n), 44'(pulses));
    wr(PTR_SOFT_RESET, SOFT_RESET_KEY);
    chk_pw();
    check("pulses", 44'(n + 1), 44'(pulses));
    rd(PTR_PULLDOWN);
    rd(PTR_SOFT_RESET);
    check("sda_out", 44'h0, 44'(sda_low));
    $display("test soft reset done");
    tally_and_finish();
  end

  // Watchdog: the run needs about 250 us.
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule : test_pprc_top

// [src/pprc_i2c_byte.sv]
module pprc_i2c_byte
  import pprc_pkg::*;
(
  input  wire logic       clk_sys,     // System clock.
  input  wire logic       rst_n,       // Synchronised reset, active low.
  input  wire logic       scl_in,      // Serial clock level.
  input  wire logic       sda_in,      // Serial data level.
  input  wire logic       ack_en,      // Acknowledge the byte just taken.
  input  wire logic       tx_next,     // Send a byte after this ack slot.
  input  wire logic [7:0] tx_byte,     // Byte to send next.
  output logic            sda_oe,      // High while pulling data low.
  output logic            start_pulse, // Start or repeated start seen.
  output logic            stop_pulse,  // Stop seen.
  output logic            rx_valid,    // One cycle: rx_byte is new.
  output logic [7:0]      rx_byte,     // Last received byte.
  output logic            tx_load      // One cycle: tx_byte was taken.
);

  // ----------------------------------------------------------------------
  // Line edges and bus conditions
  // ----------------------------------------------------------------------
  logic scl_q;
  logic sda_q;
  logic active_reg;
  logic in_ack_reg;
  logic ack_drive_reg;
  logic tx_mode_reg;
  logic mnack_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_sr_reg;
  logic [7:0] tx_sr_reg;

  // Previous line levels, used only for edge detection.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Data changing while the clock is high marks start and stop.
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  assign start_pulse = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_pulse  = scl_in & scl_q & ~sda_q & sda_in;

  // ----------------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------------
  // Bits are taken on clock rise and driven after clock fall, so the clock
  // phases must each last a few system cycles.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_reg    <= 1'b0;
      in_ack_reg    <= 1'b0;
      ack_drive_reg <= 1'b0;
      tx_mode_reg   <= 1'b0;
      mnack_reg     <= 1'b1;
      bit_cnt_reg   <= 4'h0;
      rx_sr_reg     <= 8'h00;
      tx_sr_reg     <= 8'hFF;
      rx_byte       <= 8'h00;
      rx_valid      <= 1'b0;
      tx_load       <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_load  <= 1'b0;
      if (start_pulse) begin
        active_reg    <= 1'b1;
        bit_cnt_reg   <= 4'h0;
        in_ack_reg    <= 1'b0;
        ack_drive_reg <= 1'b0;
        tx_mode_reg   <= 1'b0;
      end else if (stop_pulse) begin
        active_reg    <= 1'b0;
        in_ack_reg    <= 1'b0;
        ack_drive_reg <= 1'b0;
        tx_mode_reg   <= 1'b0;
      end else if (active_reg && scl_rise) begin
        if (in_ack_reg) begin
          mnack_reg <= sda_in;
        end else begin
          rx_sr_reg   <= {rx_sr_reg[6:0], sda_in};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7) begin
            rx_valid <= ~tx_mode_reg;
            rx_byte  <= {rx_sr_reg[6:0], sda_in};
          end
        end
      end else if (active_reg && scl_fall) begin
        if (in_ack_reg) begin
          in_ack_reg    <= 1'b0;
          ack_drive_reg <= 1'b0;
          bit_cnt_reg   <= 4'h0;
          // A master nack ends a read; the device then lets go.
          if (tx_next && (!tx_mode_reg || !mnack_reg)) begin
            tx_mode_reg <= 1'b1;
            tx_sr_reg   <= tx_byte;
            tx_load     <= 1'b1;
          end else begin
            tx_mode_reg <= 1'b0;
          end
        end else if (bit_cnt_reg == 4'h8) begin
          in_ack_reg    <= 1'b1;
          ack_drive_reg <= ~tx_mode_reg & ack_en;
        end else if (tx_mode_reg) begin
          tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Open drain: only ever pull low.
  assign sda_oe = active_reg &
                  (ack_drive_reg | (tx_mode_reg & ~in_ack_reg & ~tx_sr_reg[7]));

endmodule : pprc_i2c_byte

// [src/pprc_pkg.sv]
package pprc_pkg;

  // ----------------------------------------------------------------------
  // Register pointers and keys
  // ----------------------------------------------------------------------
  localparam logic [7:0]  PTR_POWER      = 8'h0B;
  localparam logic [7:0]  PTR_PULLDOWN   = 8'h0C;
  localparam logic [7:0]  PTR_CUR_OUT    = 8'h0E;
  localparam logic [7:0]  PTR_SOFT_RESET = 8'h0F;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h0DAC;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PWR_GLOBAL_POWER_DOWN_BIT = 10;
  localparam int PWR_REF_EN_BIT = 9;
  localparam int PIN_COUNT      = 8;
  localparam int CUR_COUNT      = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR  = 3'b011,
    ST_MSB  = 3'b010,
    ST_LSB  = 3'b110,
    ST_READ = 3'b111
  } pprc_state_t;

  typedef struct packed {
    logic [7:0] weak_pulldown_select;
    logic [3:0] current_output_enable;
    logic       global_power_down;
    logic       ref_enable;
    logic [7:0] dac_channel_sleep;
  } pprc_regs_t;

  typedef struct packed {
    logic [7:0] pin_pulldown;
    logic [3:0] cur_out_on;
    logic [7:0] volt_out_on;
    logic [7:0] dac_power_on;
    logic [7:0] range2x_on;
    logic       ref_power_on;
    logic       adc_power_on;
  } pprc_power_t;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam pprc_regs_t REGS_RST = '{
    weak_pulldown_select:  8'hFF,
    current_output_enable: 4'h0,
    global_power_down:     1'b0,
    ref_enable:            1'b0,
    dac_channel_sleep:     8'h00
  };

  localparam pprc_power_t POWER_RST = '{
    pin_pulldown: 8'hFF,
    default:      '0
  };

endpackage : pprc_pkg

// [src/pprc_power_map.sv]
module pprc_power_map
  import pprc_pkg::*;
(
  input  wire logic       clk_sys,     // System clock.
  input  wire logic       rst_n,       // Synchronised reset, active low.
  input  wire pprc_regs_t regs,        // Current register contents.
  input  wire logic [7:0] dac_config,  // Pins configured as DAC outputs.
  input  wire logic [7:0] range2x_req, // Doubled range asked per pin.
  input  wire logic       adc_busy,    // An ADC operation is running.
  output pprc_power_t     power        // Registered pin and power controls.
);

  // ----------------------------------------------------------------------
  // Pin and power decode
  // ----------------------------------------------------------------------
  pprc_power_t power_next;
  logic [7:0]  cur_wide;
  logic [7:0]  pin_free;
  logic        awake;

  // Current outputs win over voltage outputs on the shared pins.
  always_comb begin
    cur_wide = {4'h0, regs.current_output_enable};
    pin_free = ~regs.weak_pulldown_select;
    awake    = ~regs.global_power_down;
    power_next.pin_pulldown = regs.weak_pulldown_select;
    power_next.cur_out_on   = regs.current_output_enable &
                              pin_free[3:0] & {4{awake}};
    power_next.dac_power_on = dac_config & ~regs.dac_channel_sleep &
                              {8{awake}};
    power_next.volt_out_on  = power_next.dac_power_on & pin_free &
                              ~cur_wide;
    power_next.range2x_on   = range2x_req &
                              power_next.volt_out_on;
    power_next.ref_power_on = regs.ref_enable & awake;
    power_next.adc_power_on = adc_busy & awake;
  end

  // Registered so the analog controls never see decode glitches.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power <= POWER_RST;
    end else begin
      power <= power_next;
    end
  end

endmodule : pprc_power_map

// [src/pprc_top.sv]
// What this block does
// - Pull-down bits tie pins weakly low, default ones.
// - Current-output enables at 0xE, bits 0 to 3.
// - Current output enabled disables that voltage output.
// - Doubled range ignored on current-output channels.
// - ADC powered only while an operation runs.
// - Key 0x0DAC at pointer 0x0F resets registers.
// - Soft reset restores weak pull-down on pins.
// - Global power-down stops reference, DACs and ADC.
// - Reference enable powers reference and its buffer.
// - Sleep bit powers down a DAC-configured channel.
module pprc_top
  import pprc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h48 // Bus address, arbitrary default.
) (
  input  wire logic   clk_sys,          // System clock, 200 MHz.
  input  wire logic   resetn,           // Asynchronous reset, active low.
  input  wire logic   scl_in,           // Serial clock pin level.
  input  wire logic   sda_in,           // Serial data pin level.
  output logic        sda_out,          // Serial data drive value.
  output logic        sda_oe,           // Serial data drive enable.
  input  wire logic [7:0] dac_config,   // Pins configured as DAC outputs.
  input  wire logic [7:0] range2x_req,  // Doubled range asked per pin.
  input  wire logic   adc_busy,         // ADC operation in progress.
  output pprc_power_t power,            // Pin and power controls.
  output logic        soft_reset_pulse  // One cycle on keyed reset.
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Addresses 0x00-0x07 and 0x78-0x7F are reserved by the bus itself.
  if ((DEV_ADDR < 7'h08) || (DEV_ADDR > 7'h77)) begin : g_bad_addr
    $error("DEV_ADDR falls in a reserved bus address range.");
  end

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  // Two flops so the release never lands near a clock edge.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Serial byte engine
  // ----------------------------------------------------------------------
  pprc_state_t state_reg;
  logic        start_pulse;
  logic        stop_pulse;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        tx_load;
  logic [7:0]  tx_byte;
  logic        ack_en;
  logic        tx_next;

  // A mismatched address byte sends the state back to IDLE, which suppresses the ack.
  assign ack_en  = (state_reg != ST_IDLE);
  assign tx_next = (state_reg == ST_READ);
  assign sda_out = 1'b0;

  pprc_i2c_byte u_byte (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .ack_en      (ack_en),
    .tx_next     (tx_next),
    .tx_byte     (tx_byte),
    .sda_oe      (sda_oe),
    .start_pulse (start_pulse),
    .stop_pulse  (stop_pulse),
    .rx_valid    (rx_valid),
    .rx_byte     (rx_byte),
    .tx_load     (tx_load)
  );

  // ----------------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [7:0] msb_reg;
  logic       rd_lsb_reg;

  // Address, pointer, then data byte pairs until stop.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (start_pulse) begin
      state_reg <= ST_ADDR;
    end else if (stop_pulse) begin
      state_reg <= ST_IDLE;
    end else if (rx_valid) begin
      case (state_reg)
        ST_ADDR: begin
          if (rx_byte[7:1] != DEV_ADDR) begin
            state_reg <= ST_IDLE;
          end else if (rx_byte[0]) begin
            state_reg <= ST_READ;
          end else begin
            state_reg <= ST_PTR;
          end
        end
        ST_PTR:  state_reg <= ST_MSB;
        ST_MSB:  state_reg <= ST_LSB;
        ST_LSB:  state_reg <= ST_MSB;
        ST_READ: state_reg <= ST_READ;
        ST_IDLE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Pointer and high data byte captured as they arrive.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= 8'h00;
      msb_reg <= 8'h00;
    end else if (rx_valid && (state_reg == ST_PTR)) begin
      ptr_reg <= rx_byte;
    end else if (rx_valid && (state_reg == ST_MSB)) begin
      msb_reg <= rx_byte;
    end
  end

  // Reads give the high byte first, then alternate.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_lsb_reg <= 1'b0;
    end else if (start_pulse) begin
      rd_lsb_reg <= 1'b0;
    end else if (tx_load) begin
      rd_lsb_reg <= ~rd_lsb_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  pprc_regs_t  regs_reg;
  logic        wr_pulse;
  logic [15:0] wr_word;
  logic        key_hit;
  logic        key_miss;
  logic [15:0] rd_word;

  assign wr_pulse = rx_valid && (state_reg == ST_LSB);
  assign wr_word  = {msb_reg, rx_byte};
  assign key_hit  = wr_pulse && (ptr_reg == PTR_SOFT_RESET) &&
                    (wr_word == SOFT_RESET_KEY);
  assign key_miss = wr_pulse && (ptr_reg == PTR_SOFT_RESET) &&
                    (wr_word != SOFT_RESET_KEY);

  // Reserved bits are dropped on write, so careless hosts cannot set them.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regs_reg <= REGS_RST;
    end else if (key_hit) begin
      regs_reg <= REGS_RST;
    end else if (wr_pulse) begin
      case (ptr_reg)
        PTR_PULLDOWN: begin
          regs_reg.weak_pulldown_select <= wr_word[7:0];
        end
        PTR_CUR_OUT: begin
          regs_reg.current_output_enable <= wr_word[3:0];
        end
        PTR_POWER: begin
          regs_reg.global_power_down <= wr_word[PWR_GLOBAL_POWER_DOWN_BIT];
          regs_reg.ref_enable        <= wr_word[PWR_REF_EN_BIT];
          regs_reg.dac_channel_sleep <= wr_word[7:0];
        end
        default: begin
          regs_reg <= regs_reg;
        end
      endcase
    end
  end

  // Other blocks of the device return to defaults on this pulse too.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= key_hit;
    end
  end

  // Reserved and write-only locations read as zero.
  always_comb begin
    rd_word = 16'h0000;
    case (ptr_reg)
      PTR_PULLDOWN: rd_word[7:0] = regs_reg.weak_pulldown_select;
      PTR_CUR_OUT:  rd_word[3:0] = regs_reg.current_output_enable;
      PTR_POWER: begin
        rd_word[PWR_GLOBAL_POWER_DOWN_BIT] = regs_reg.global_power_down;
        rd_word[PWR_REF_EN_BIT] = regs_reg.ref_enable;
        rd_word[7:0]            = regs_reg.dac_channel_sleep;
      end
      default:      rd_word = 16'h0000;
    endcase
  end

  assign tx_byte = rd_lsb_reg ? rd_word[7:0] : rd_word[15:8];

  // ----------------------------------------------------------------------
  // Pin and power outputs
  // ----------------------------------------------------------------------
  pprc_power_map u_map (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .regs        (regs_reg),
    .dac_config  (dac_config),
    .range2x_req (range2x_req),
    .adc_busy    (adc_busy),
    .power       (power)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_key_write;
    key_hit;
  endsequence

  sequence s_defaults_then_pins;
    (regs_reg == REGS_RST) ##1 (power.pin_pulldown == 8'hFF);
  endsequence

  property p_soft_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      s_key_write |=> s_defaults_then_pins;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("Keyed reset did not restore defaults.");

  property p_soft_reset_pins;
    @(posedge clk_sys) disable iff (!rst_n)
      key_hit |=> soft_reset_pulse ##1
                  ((power.pin_pulldown == 8'hFF) && !soft_reset_pulse);
  endproperty
  a_soft_reset_pins: assert property (p_soft_reset_pins)
    else $error("Pins not pulled down after keyed reset.");

  property p_bad_key;
    @(posedge clk_sys) disable iff (!rst_n)
      key_miss |=> $stable(regs_reg);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("Wrong reset value changed registers.");

  property p_cur_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_pulse && ptr_reg == 8'h0E) |=>
        regs_reg.current_output_enable == $past(rx_byte[3:0]);
  endproperty
  a_cur_write: assert property (p_cur_write)
    else $error("Current enable write at 0xE not stored.");

  property p_cur_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 (($past(regs_reg.current_output_enable) &
            power.volt_out_on[3:0]) == 4'h0);
  endproperty
  a_cur_wins: assert property (p_cur_wins)
    else $error("Voltage output on with current output enabled.");

  property p_range_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 (($past(regs_reg.current_output_enable) &
            power.range2x_on[3:0]) == 4'h0);
  endproperty
  a_range_ignored: assert property (p_range_ignored)
    else $error("Doubled range active on a current channel.");

  property p_adc_auto;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 power.adc_power_on == ($past(adc_busy) &&
                                 !$past(regs_reg.global_power_down));
  endproperty
  a_adc_auto: assert property (p_adc_auto)
    else $error("ADC power does not follow its activity.");

  property p_global_down;
    @(posedge clk_sys) disable iff (!rst_n)
      regs_reg.global_power_down |=>
        !power.ref_power_on && !power.adc_power_on &&
        power.dac_power_on == 8'h00 && power.cur_out_on == 4'h0;
  endproperty
  a_global_down: assert property (p_global_down)
    else $error("Unit powered while global power-down set.");

  property p_ref_enable;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 power.ref_power_on == ($past(regs_reg.ref_enable) &&
                                 !$past(regs_reg.global_power_down));
  endproperty
  a_ref_enable: assert property (p_ref_enable)
    else $error("Reference power does not follow its enable.");

  property p_sleep;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 (($past(regs_reg.dac_channel_sleep) &
            power.dac_power_on) == 8'h00);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Sleeping DAC channel still powered.");

  property p_pulldown;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 power.pin_pulldown == $past(regs_reg.weak_pulldown_select);
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("Pin pull-downs do not follow their register.");

  property p_cur_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(rst_n) |-> regs_reg.current_output_enable == 4'h0 &&
                       regs_reg.weak_pulldown_select == 8'hFF;
  endproperty
  a_cur_reset: assert property (p_cur_reset)
    else $error("Registers not at defaults after reset.");

endmodule : pprc_top
